// ==== logic/irfc_pkg.sv ====
`default_nettype none
package irfc_pkg;
   typedef enum logic [1:0] {
      WINDOW_FORMAT_CHOICE   = 2'b00,
      SUMMING_FORMAT_CHOICE  = 2'b01,
      SKIPPING_FORMAT_CHOICE = 2'b10
   } irfc_format_type;

   typedef enum logic [3:0] {
      SEL_FORMAT = 4'b0000,
      SEL_WIDTH  = 4'b0001,
      SEL_HEIGHT = 4'b0010,
      SEL_HSTART = 4'b0011,
      SEL_VSTART = 4'b0100,
      SEL_HSUM   = 4'b0101,
      SEL_VSUM   = 4'b0110,
      SEL_STREAM = 4'b0111,
      SEL_EVENT  = 4'b1000,
      SEL_TEST   = 4'b1001
   } irfc_sel_type;

   typedef enum logic [2:0] {
      ID_VENDOR = 3'b000,
      ID_MODEL  = 3'b001,
      ID_MANUF  = 3'b010,
      ID_VERS   = 3'b011,
      ID_SERIAL = 3'b100
   } irfc_id_type;
endpackage
`default_nettype wire

// ==== logic/irfc_regs.svh ====
`ifndef IRFC_REGS_SVH
`define IRFC_REGS_SVH
// window grid and limits, in pixels
`define IRFC_H_STEP       11'h004
`define IRFC_V_STEP       11'h002
`define IRFC_MIN_WIDTH    11'h040
`define IRFC_MIN_HEIGHT   11'h040
`define IRFC_FULL_WIDTH   11'h500
`define IRFC_FULL_HEIGHT  11'h400
// reset values
`define IRFC_RST_WIDTH    11'h500
`define IRFC_RST_HEIGHT   11'h400
`define IRFC_RST_HSTART   11'h000
`define IRFC_RST_VSTART   11'h000
`define IRFC_RST_SUM      2'h1
`define IRFC_MAX_SUM      2'h2
// identity field string length in bytes
`define IRFC_ID_LEN       16
`endif

// ==== logic/irfc_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "irfc_regs.svh"

// Behaviour
// - three formats, window after reset
// - format writes ignored while streaming
// - in window format rows outside window read fast
// - in window format frame length follows height, not width; 1024 rows otherwise
// - one rectangular window only
// - horizontal grid 4, vertical grid 2
// - window 64x64 to 1280x1024, inside image
// - window writes ignored while streaming
// - summing mode adds 2x2 pixels
// - stream channel open bit read/write
// - event notify bit read/write
// - test command emits one event
// - user name kept in non-volatile store
// - read-only identity string fields
// - one sum factor write sets both
// - acquisition start needs open channel
module irfc_top
   import irfc_pkg::*;
#(
   parameter int                    PIX_W     = 10,
   parameter int                    NAME_LEN  = 16,
   parameter logic [8*16-1:0]       VENDOR_ID = "VENDOR_A", // arbitrary value
   parameter logic [8*16-1:0]       MODEL_ID  = "MODEL_A",  // arbitrary value
   parameter logic [8*16-1:0]       MANUF_ID  = "MANUF_A",  // arbitrary value
   parameter logic [8*16-1:0]       VERS_ID   = "1.0",      // arbitrary value
   parameter logic [8*16-1:0]       SERIAL_ID = "00000001"  // arbitrary value
) (
   // clock and reset
   input  wire logic                CLK_I,
   input  wire logic                RST_N_I,
   // configuration write port
   input  wire logic                CFG_WR_I,
   input  wire logic [3:0]          CFG_SEL_I,
   input  wire logic [15:0]         CFG_DATA_I,
   output logic                     CFG_REJECT_O,
   // acquisition commands
   input  wire logic                ACQ_START_I,
   input  wire logic                ACQ_STOP_I,
   output logic                     STREAMING_O,
   // settings in effect
   output logic [1:0]               FORMAT_O,
   output logic [10:0]              WIDTH_O,
   output logic [10:0]              HEIGHT_O,
   output logic [10:0]              HSTART_O,
   output logic [10:0]              VSTART_O,
   output logic [1:0]               HSUM_O,
   output logic [1:0]               VSUM_O,
   output logic                     STREAM_OPEN_O,
   output logic                     EVENT_ON_O,
   output logic                     TEST_EVENT_O,
   // row sequencer
   input  wire logic                FRAME_START_I,
   input  wire logic                ROW_STEP_I,
   output logic                     ROW_FAST_O,
   output logic [10:0]              FRAME_ROWS_O,
   // pixel summing: two vertically adjacent pixels per column
   input  wire logic                PIX_VALID_I,
   input  wire logic [PIX_W-1:0]    PIX_TOP_I,
   input  wire logic [PIX_W-1:0]    PIX_BOT_I,
   output logic                     SUM_VALID_O,
   output logic [PIX_W+1:0]         SUM_DATA_O,
   // user name
   input  wire logic                NAME_WR_I,
   input  wire logic [3:0]          NAME_IDX_I,
   input  wire logic [7:0]          NAME_DATA_I,
   input  wire logic                NAME_RD_I,
   output logic [7:0]               NAME_RDATA_O,
   input  wire logic                NV_LOAD_I,
   output logic                     NV_STORE_O,
   output logic [3:0]               NV_IDX_O,
   output logic [7:0]               NV_DATA_O,
   // identity read
   input  wire logic                ID_RD_I,
   input  wire logic [2:0]          ID_SEL_I,
   input  wire logic [3:0]          ID_IDX_I,
   output logic [7:0]               ID_RDATA_O
);
   logic [1:0]                      rst_sync_reg;
   logic                            rst_n;
   irfc_format_type                 format_reg;
   logic [10:0]                     width_reg;
   logic [10:0]                     height_reg;
   logic [10:0]                     hstart_reg;
   logic [10:0]                     vstart_reg;
   logic [1:0]                      hsum_reg;
   logic [1:0]                      vsum_reg;
   logic                            open_reg;
   logic                            event_reg;
   logic                            run_reg;
   logic                            reject_reg;
   logic                            test_reg;
   logic [10:0]                     row_reg;
   logic                            fast_reg;
   logic [10:0]                     rows_reg;
   logic                            half_reg;
   logic [PIX_W:0]                  col_sum_reg;
   logic                            sum_valid_reg;
   logic [PIX_W+1:0]                sum_data_reg;
   logic [7:0]                      name_mem [NAME_LEN];
   logic [7:0]                      name_rdata_reg;
   logic                            nv_store_reg;
   logic [3:0]                      nv_idx_reg;
   logic [7:0]                      nv_data_reg;
   logic [7:0]                      id_rdata_reg;
   logic [10:0]                     val;
   logic                            accept;
   logic                            cfg_wr;
   logic [PIX_W:0]                  col_sum_next;

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   assign val = CFG_DATA_I[10:0];
   assign cfg_wr = CFG_WR_I && (CFG_DATA_I[15:11] == 5'h00 || CFG_SEL_I == SEL_STREAM ||
                                CFG_SEL_I == SEL_EVENT || CFG_SEL_I == SEL_TEST);

   // write validation; a refused write leaves the old value in place
   always_comb begin
      accept = 1'b0;
      case (irfc_sel_type'(CFG_SEL_I))
         SEL_FORMAT:
            accept = !run_reg && val <= 11'(SKIPPING_FORMAT_CHOICE);
         SEL_WIDTH:
            accept = !run_reg && val[1:0] == 2'h0 && val >= `IRFC_MIN_WIDTH &&
                     ({1'b0, val} + {1'b0, hstart_reg} <= {1'b0, `IRFC_FULL_WIDTH});
         SEL_HEIGHT:
            accept = !run_reg && val[0] == 1'b0 && val >= `IRFC_MIN_HEIGHT &&
                     ({1'b0, val} + {1'b0, vstart_reg} <= {1'b0, `IRFC_FULL_HEIGHT});
         SEL_HSTART:
            accept = !run_reg && val[1:0] == 2'h0 &&
                     ({1'b0, val} + {1'b0, width_reg} <= {1'b0, `IRFC_FULL_WIDTH});
         SEL_VSTART:
            accept = !run_reg && val[0] == 1'b0 &&
                     ({1'b0, val} + {1'b0, height_reg} <= {1'b0, `IRFC_FULL_HEIGHT});
         SEL_HSUM, SEL_VSUM:
            accept = !run_reg && val != 11'h000 && val <= {9'h000, `IRFC_MAX_SUM};
         SEL_STREAM, SEL_EVENT, SEL_TEST:
            accept = 1'b1;
         default:
            accept = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         format_reg <= WINDOW_FORMAT_CHOICE;
         width_reg  <= `IRFC_RST_WIDTH;
         height_reg <= `IRFC_RST_HEIGHT;
         hstart_reg <= `IRFC_RST_HSTART;
         vstart_reg <= `IRFC_RST_VSTART;
         hsum_reg   <= `IRFC_RST_SUM;
         vsum_reg   <= `IRFC_RST_SUM;
         open_reg   <= 1'b0;
         event_reg  <= 1'b0;
      end else if (cfg_wr && accept) begin
         case (irfc_sel_type'(CFG_SEL_I))
            SEL_FORMAT: format_reg <= irfc_format_type'(val[1:0]);
            SEL_WIDTH:  width_reg  <= val;
            SEL_HEIGHT: height_reg <= val;
            SEL_HSTART: hstart_reg <= val;
            SEL_VSTART: vstart_reg <= val;
            SEL_HSUM, SEL_VSUM: begin
               hsum_reg <= val[1:0];
               vsum_reg <= val[1:0];
            end
            SEL_STREAM: open_reg  <= CFG_DATA_I[0];
            SEL_EVENT:  event_reg <= CFG_DATA_I[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         reject_reg <= 1'b0;
         test_reg   <= 1'b0;
      end else begin
         reject_reg <= CFG_WR_I && !(cfg_wr && accept);
         test_reg   <= cfg_wr && CFG_SEL_I == SEL_TEST;
      end
   end

   // streaming runs from an accepted start until stop or channel close
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         run_reg <= 1'b0;
      end else if (ACQ_STOP_I || !open_reg) begin
         run_reg <= 1'b0;
      end else if (ACQ_START_I) begin
         run_reg <= 1'b1;
      end
   end

   // row sequencer: in window format only the window rows are read at normal speed
   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         row_reg  <= 11'h000;
         fast_reg <= 1'b0;
         rows_reg <= `IRFC_RST_HEIGHT;
      end else begin
         if (FRAME_START_I) begin
            row_reg  <= 11'h000;
            rows_reg <= (format_reg == WINDOW_FORMAT_CHOICE) ? height_reg
                                                             : `IRFC_FULL_HEIGHT;
         end else if (ROW_STEP_I) begin
            row_reg  <= row_reg + 11'h001;
            fast_reg <= (format_reg == WINDOW_FORMAT_CHOICE) &&
                        (row_reg < vstart_reg ||
                         {1'b0, row_reg} >= {1'b0, vstart_reg} + {1'b0, height_reg});
         end
      end
   end

   // 2x2 sum: column pair of vertical sums
   assign col_sum_next = {1'b0, PIX_TOP_I} + {1'b0, PIX_BOT_I};

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         half_reg      <= 1'b0;
         col_sum_reg   <= '0;
         sum_valid_reg <= 1'b0;
         sum_data_reg  <= '0;
      end else begin
         sum_valid_reg <= 1'b0;
         if (FRAME_START_I || format_reg != SUMMING_FORMAT_CHOICE) begin
            half_reg <= 1'b0;
         end else if (PIX_VALID_I) begin
            half_reg <= !half_reg;
            if (!half_reg) begin
               col_sum_reg <= col_sum_next;
            end else begin
               sum_valid_reg <= 1'b1;
               sum_data_reg  <= {1'b0, col_sum_reg} + {1'b0, col_sum_next};
            end
         end
      end
   end

   // user name: host writes go to the store unless a load comes in the same cycle; load writes come back from it
   always_ff @(posedge CLK_I) begin
      if (NAME_WR_I || NV_LOAD_I) begin
         name_mem[NAME_IDX_I] <= NAME_DATA_I;
      end
   end

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         nv_store_reg   <= 1'b0;
         nv_idx_reg     <= 4'h0;
         nv_data_reg    <= 8'h00;
         name_rdata_reg <= 8'h00;
      end else begin
         nv_store_reg <= NAME_WR_I && !NV_LOAD_I;
         if (NAME_WR_I) begin
            nv_idx_reg  <= NAME_IDX_I;
            nv_data_reg <= NAME_DATA_I;
         end
         if (NAME_RD_I) begin
            name_rdata_reg <= name_mem[NAME_IDX_I];
         end
      end
   end

   // identity strings, byte 0 is the first character
   function automatic logic [7:0] id_byte(input logic [8*16-1:0] s, input logic [3:0] i);
      logic [8*16-1:0] t;
      t = s;
      while (t != '0 && t[8*16-1 -: 8] == 8'h00) begin
         t = t << 8;
      end
      return t[8*16-1 - 8*i -: 8];
   endfunction

   always_ff @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         id_rdata_reg <= 8'h00;
      end else if (ID_RD_I) begin
         case (irfc_id_type'(ID_SEL_I))
            ID_VENDOR: id_rdata_reg <= id_byte(VENDOR_ID, ID_IDX_I);
            ID_MODEL:  id_rdata_reg <= id_byte(MODEL_ID, ID_IDX_I);
            ID_MANUF:  id_rdata_reg <= id_byte(MANUF_ID, ID_IDX_I);
            ID_VERS:   id_rdata_reg <= id_byte(VERS_ID, ID_IDX_I);
            ID_SERIAL: id_rdata_reg <= id_byte(SERIAL_ID, ID_IDX_I);
            default:   id_rdata_reg <= 8'h00;
         endcase
      end
   end

   assign CFG_REJECT_O  = reject_reg;
   assign STREAMING_O   = run_reg;
   assign FORMAT_O      = format_reg;
   assign WIDTH_O       = width_reg;
   assign HEIGHT_O      = height_reg;
   assign HSTART_O      = hstart_reg;
   assign VSTART_O      = vstart_reg;
   assign HSUM_O        = hsum_reg;
   assign VSUM_O        = vsum_reg;
   assign STREAM_OPEN_O = open_reg;
   assign EVENT_ON_O    = event_reg;
   assign TEST_EVENT_O  = test_reg;
   assign ROW_FAST_O    = fast_reg;
   assign FRAME_ROWS_O  = rows_reg;
   assign SUM_VALID_O   = sum_valid_reg;
   assign SUM_DATA_O    = sum_data_reg;
   assign NAME_RDATA_O  = name_rdata_reg;
   assign NV_STORE_O    = nv_store_reg;
   assign NV_IDX_O      = nv_idx_reg;
   assign NV_DATA_O     = nv_data_reg;
   assign ID_RDATA_O    = id_rdata_reg;
endmodule
`default_nettype wire

// ==== tb/irfc_nv_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module irfc_nv_model (
   input wire logic       clk_i,
   input wire logic       store_i,
   input wire logic [3:0] idx_i,
   input wire logic [7:0] data_i
);
   logic [7:0] mem [16];
   int         stores = 0;
   // non-volatile byte store, written one byte per strobe
   always @(posedge clk_i) begin
      if (store_i) begin
         mem[idx_i] <= data_i;
         stores <= stores + 1;
      end
   end
endmodule
`default_nettype wire

// ==== tb/irfc_top_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module irfc_top_chk
   import irfc_pkg::*;
(
   // clock, reset and inputs
   input wire logic        CLK_I,
   input wire logic        RST_N_I,
   input wire logic        CFG_WR_I,
   input wire logic [3:0]  CFG_SEL_I,
   input wire logic [15:0] CFG_DATA_I,
   input wire logic        ACQ_START_I,
   input wire logic        FRAME_START_I,
   // outputs watched
   input wire logic        STREAMING_O,
   input wire logic [1:0]  FORMAT_O,
   input wire logic [10:0] WIDTH_O,
   input wire logic [10:0] HEIGHT_O,
   input wire logic [10:0] HSTART_O,
   input wire logic [10:0] VSTART_O,
   input wire logic [1:0]  HSUM_O,
   input wire logic [1:0]  VSUM_O,
   input wire logic        STREAM_OPEN_O,
   input wire logic        TEST_EVENT_O,
   input wire logic [10:0] FRAME_ROWS_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   chk_fmt_frozen: assert property (STREAMING_O |=> $stable(FORMAT_O))
      else $error("format changed while streaming");
   chk_win_frozen: assert property (STREAMING_O |=> $stable({WIDTH_O, HEIGHT_O,
      HSTART_O, VSTART_O})) else $error("window changed while streaming");
   chk_win_grid: assert property (WIDTH_O[1:0] == 2'h0 && HSTART_O[1:0] == 2'h0
      && !HEIGHT_O[0] && !VSTART_O[0]) else $error("window off grid");
   chk_win_range: assert property (WIDTH_O >= 11'h040 && HEIGHT_O >= 11'h040
      && {1'b0, WIDTH_O} + {1'b0, HSTART_O} <= 12'h500
      && {1'b0, HEIGHT_O} + {1'b0, VSTART_O} <= 12'h400) else $error("window out of range");
   chk_sum_pair: assert property (HSUM_O == VSUM_O && HSUM_O inside {2'h1, 2'h2})
      else $error("sum factors differ");
   chk_fmt_legal: assert property (FORMAT_O <= 2'h2) else $error("format illegal");
   chk_test_event: assert property (TEST_EVENT_O ==
      $past(CFG_WR_I && CFG_SEL_I == SEL_TEST))
      else $error("test event not one cycle after command");
   chk_open_write: assert property (CFG_WR_I && CFG_SEL_I == SEL_STREAM &&
      CFG_DATA_I[15:1] == 15'h0 |=> STREAM_OPEN_O == $past(CFG_DATA_I[0]))
      else $error("stream open bit not written");
   chk_start_closed: assert property (ACQ_START_I && !STREAM_OPEN_O && !STREAMING_O
      |=> !STREAMING_O) else $error("started with channel closed");
   chk_frame_rows: assert property ($rose(FRAME_START_I) |=> FRAME_ROWS_O ==
      (($past(FORMAT_O) == 2'h0) ? $past(HEIGHT_O) : 11'h400)) else $error("frame rows wrong");
   cover property (STREAMING_O && CFG_WR_I);
   cover property (TEST_EVENT_O);
   cover property (FORMAT_O == SUMMING_FORMAT_CHOICE && FRAME_START_I);
endmodule
`default_nettype wire

// ==== tb/irfc_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module irfc_top_tb
   import irfc_pkg::*;
;
   typedef struct packed {logic [3:0] s; logic [15:0] d; logic r; logic [15:0] e;} irfcv_row_type;
   logic        clk = 0, rst_n = 0, wr = 0, start = 0, stop = 0, fst = 0, rstep = 0;
   logic        pv = 0, nwr = 0, nrd = 0, nld = 0, idrd = 0, rej, strm, sopen, evt, tev;
   logic        fast, sv, nst;
   logic [3:0]  sel = 0, nidx = 0, iidx = 0, nvi;
   logic [15:0] data = 0;
   logic [9:0]  pt = 0, pb = 0;
   logic [7:0]  nd = 0, nrdat, nvd, idat;
   logic [2:0]  isel = 0;
   logic [1:0]  fmt, hs, vs;
   logic [10:0] w, h, hx, vy, rows;
   logic [11:0] sd;
   int          error_cnt = 0, checked = 0;
   irfcv_row_type tbl [24] = '{
      '{SEL_WIDTH, 16'h0280, 0, 16'h0280}, '{SEL_WIDTH, 16'h0282, 1, 16'h0280},
      '{SEL_WIDTH, 16'h003C, 1, 16'h0280}, '{SEL_HSTART, 16'h0280, 0, 16'h0280},
      '{SEL_HSTART, 16'h0284, 1, 16'h0280}, '{SEL_HSTART, 16'h0002, 1, 16'h0280},
      '{SEL_WIDTH, 16'h0284, 1, 16'h0280}, '{SEL_HEIGHT, 16'h0040, 0, 16'h0040},
      '{SEL_HEIGHT, 16'h003F, 1, 16'h0040}, '{SEL_VSTART, 16'h03C0, 0, 16'h03C0},
      '{SEL_VSTART, 16'h03C2, 1, 16'h03C0}, '{SEL_VSTART, 16'h0001, 1, 16'h03C0},
      '{SEL_FORMAT, 16'h0003, 1, 16'h0000}, '{SEL_FORMAT, 16'h0001, 0, 16'h0001},
      '{SEL_FORMAT, 16'h0002, 0, 16'h0002}, '{SEL_FORMAT, 16'h0000, 0, 16'h0000},
      '{SEL_HSUM, 16'h0002, 0, 16'h000A}, '{SEL_VSUM, 16'h0000, 1, 16'h000A},
      '{SEL_VSUM, 16'h0003, 1, 16'h000A}, '{SEL_VSUM, 16'h0001, 0, 16'h0005},
      '{SEL_EVENT, 16'h0001, 0, 16'h0001}, '{SEL_EVENT, 16'h0000, 0, 16'h0000},
      '{4'hF, 16'h0001, 1, 16'h0000}, '{SEL_WIDTH, 16'h8280, 1, 16'h0280}};
   always #2 clk = ~clk;
   irfc_top i_dut (.CLK_I(clk), .RST_N_I(rst_n), .CFG_WR_I(wr), .CFG_SEL_I(sel),
      .CFG_DATA_I(data), .CFG_REJECT_O(rej), .ACQ_START_I(start), .ACQ_STOP_I(stop),
      .STREAMING_O(strm), .FORMAT_O(fmt), .WIDTH_O(w), .HEIGHT_O(h), .HSTART_O(hx),
      .VSTART_O(vy), .HSUM_O(hs), .VSUM_O(vs), .STREAM_OPEN_O(sopen), .EVENT_ON_O(evt),
      .TEST_EVENT_O(tev), .FRAME_START_I(fst), .ROW_STEP_I(rstep), .ROW_FAST_O(fast),
      .FRAME_ROWS_O(rows), .PIX_VALID_I(pv), .PIX_TOP_I(pt), .PIX_BOT_I(pb),
      .SUM_VALID_O(sv), .SUM_DATA_O(sd), .NAME_WR_I(nwr), .NAME_IDX_I(nidx),
      .NAME_DATA_I(nd), .NAME_RD_I(nrd), .NAME_RDATA_O(nrdat), .NV_LOAD_I(nld),
      .NV_STORE_O(nst), .NV_IDX_O(nvi), .NV_DATA_O(nvd), .ID_RD_I(idrd), .ID_SEL_I(isel),
      .ID_IDX_I(iidx), .ID_RDATA_O(idat));
   irfc_nv_model i_nv (.clk_i(clk), .store_i(nst), .idx_i(nvi), .data_i(nvd));
   function automatic logic [15:0] cur(input logic [3:0] s);
      case (s)
         SEL_FORMAT: cur = {14'h0, fmt};
         SEL_WIDTH: cur = {5'h0, w};
         SEL_HEIGHT: cur = {5'h0, h};
         SEL_HSTART: cur = {5'h0, hx};
         SEL_VSTART: cur = {5'h0, vy};
         SEL_HSUM, SEL_VSUM: cur = {12'h0, hs, vs};
         SEL_EVENT: cur = {15'h0, evt};
         default: cur = {15'h0, sopen};
      endcase
   endfunction
   task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // one-cycle strobes, one bit each: {idrd, nld, nrd, nwr, rstep, fst, stop, start, wr}
   localparam logic [8:0] p_wr = 9'h001, p_start = 9'h002, p_stop = 9'h004, p_fst = 9'h008;
   localparam logic [8:0] p_step = 9'h010, p_nwr = 9'h020, p_nrd = 9'h040, p_nld = 9'h080;
   localparam logic [8:0] p_idrd = 9'h100;
   task automatic pulse(input logic [8:0] m);
      @(posedge clk);
      #1 {idrd, nld, nrd, nwr, rstep, fst, stop, start, wr} = m;
      @(posedge clk);
      #1 {idrd, nld, nrd, nwr, rstep, fst, stop, start, wr} = 9'h000;
   endtask
   task automatic cfg(input logic [3:0] s, input logic [15:0] d);
      sel = s;
      data = d;
      pulse(p_wr);
   endtask
   task automatic do_reset();
      rst_n = 0;
      repeat (5) @(posedge clk);
      #1 rst_n = 1;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      do_reset();
      foreach (tbl[i]) begin
         cfg(tbl[i].s, tbl[i].d);
         chk("reject", {15'h0, tbl[i].r}, {15'h0, rej});
         chk("value", tbl[i].e, cur(tbl[i].s));
      end
      $display("table test done");
      do_reset();
      chk("reset", {2'h0, 11'h500, 11'h400, 22'h0}, {fmt, w, h, hx, vy});
      chk("reset sums", {4'h5, 4'h0, 11'h400}, {hs, vs, sopen, evt, tev, strm, rows});
      $display("reset test done");
      cfg(SEL_STREAM, 16'h0001);
      pulse(p_start);
      chk("streaming", 1, strm);
      cfg(SEL_FORMAT, 16'h0001);
      chk("fmt refused", 16'h0001, {fmt, 13'h0, rej});
      cfg(SEL_WIDTH, 16'h0280);
      chk("width refused", {11'h500, 1'b1}, {w, rej});
      cfg(SEL_EVENT, 16'h0001);
      chk("event", 1, evt);
      pulse(p_stop);
      chk("stopped", 0, strm);
      cfg(SEL_STREAM, 16'h0000);
      pulse(p_start);
      chk("closed start", 0, strm);
      cfg(SEL_TEST, 16'h0000);
      chk("test event", 1, tev);
      @(posedge clk);
      #1 chk("test event end", 0, tev);
      $display("stream test done");
      cfg(SEL_HEIGHT, 16'h0040);
      cfg(SEL_VSTART, 16'h0002);
      pulse(p_fst);
      chk("rows", 16'h0040, {5'h0, rows});
      cfg(SEL_WIDTH, 16'h0040);
      pulse(p_fst);
      chk("rows narrow", 16'h0040, {5'h0, rows});
      for (int r = 0; r < 68; r++) begin
         pulse(p_step);
         chk("fast row", {15'h0, r < 2 || r >= 66}, {15'h0, fast});
      end
      cfg(SEL_FORMAT, 16'h0001);
      pulse(p_fst);
      pulse(p_step);
      chk("sum rows", 16'h0400, {4'h0, fast, rows});
      @(posedge clk);
      #1 {pv, pt, pb} = {1'b1, 10'h3FF, 10'h3FF};
      @(posedge clk);
      #1 {pt, pb} = {10'h3FF, 10'h3FD};
      @(posedge clk);
      #1 pv = 0;
      chk("sum", 16'h1FFA, {3'h0, sv, sd});
      $display("readout test done");
      {nidx, nd} = {4'h5, 8'hA5};
      pulse(p_nwr);
      @(posedge clk);
      #1 chk("nv store", 16'h01A5, {i_nv.stores[7:0], i_nv.mem[5]});
      pulse(p_nrd);
      chk("name", 16'h00A5, {8'h0, nrdat});
      nd = 8'h3C;
      pulse(p_nld);
      pulse(p_nrd);
      chk("name load", 16'h013C, {i_nv.stores[7:0], nrdat});
      {isel, iidx} = {ID_VENDOR, 4'h0};
      pulse(p_idrd);
      chk("vendor", 16'h0056, {8'h0, idat});
      {isel, iidx} = {ID_SERIAL, 4'h7};
      pulse(p_idrd);
      chk("serial", 16'h0031, {8'h0, idat});
      iidx = 4'hF;
      pulse(p_idrd);
      chk("serial end", 16'h0000, {8'h0, idat});
      $display("name and identity test done");
      print_verdict();
   end
endmodule
bind irfc_top irfc_top_chk i_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CFG_WR_I(CFG_WR_I),
   .CFG_SEL_I(CFG_SEL_I), .CFG_DATA_I(CFG_DATA_I), .ACQ_START_I(ACQ_START_I),
   .FRAME_START_I(FRAME_START_I), .STREAMING_O(STREAMING_O), .FORMAT_O(FORMAT_O),
   .WIDTH_O(WIDTH_O), .HEIGHT_O(HEIGHT_O), .HSTART_O(HSTART_O), .VSTART_O(VSTART_O),
   .HSUM_O(HSUM_O), .VSUM_O(VSUM_O), .STREAM_OPEN_O(STREAM_OPEN_O),
   .TEST_EVENT_O(TEST_EVENT_O), .FRAME_ROWS_O(FRAME_ROWS_O));
`default_nettype wire
